// [design/fcf_pkg.sv]
// Purpose: Shared constants for the flash command front end.
// Assumes: One-byte opcodes, most significant bit first.
// Notes: Only codes that the front end acts on are listed.
package fcf_pkg;
  localparam logic [7:0] OP_WRITE_EN     = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS    = 8'h04;
  localparam logic [7:0] OP_READ_STAT1   = 8'h05;
  localparam logic [7:0] OP_WRITE_STAT12 = 8'h01;
  localparam logic [7:0] OP_WRITE_STAT3  = 8'h11;
  localparam logic [7:0] OP_READ_EXT     = 8'hC8;
  localparam logic [7:0] OP_WRITE_EXT    = 8'hC5;
  localparam logic [7:0] OP_ENTER_WIDE   = 8'hB7;
  localparam logic [7:0] OP_EXIT_WIDE    = 8'hE9;
  localparam logic [7:0] OP_PROG_WIDE    = 8'h12;
  localparam logic [7:0] OP_QPROG_WIDE   = 8'h34;
  localparam logic [7:0] OP_SECT_ERASE   = 8'h21;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_POWER_DOWN   = 8'hB9;
  localparam logic [7:0] OP_DTR_QREAD    = 8'hED;

  localparam int         EXT_LPE_BIT     = 7;
  localparam int         EXT_URS_BIT     = 0;
  localparam logic [7:0] EXT_RESET       = 8'h00;
  localparam logic [7:0] EXT_KEEP_MASK   = 8'h81;
  localparam int         STAT1_WL_BIT    = 1;
  localparam logic [7:0] STAT1_BASE      = 8'h00;
  localparam logic [7:0] LEARN_PATTERN   = 8'h34;

  localparam int         ADDR_BYTES_NARROW = 3;
  localparam int         ADDR_BYTES_WIDE   = 4;
  localparam int         DTR_MODE_CLKS     = 1;
  localparam int         DTR_DUMMY_CLKS    = 10;
  localparam int         LEARN_CLKS        = 4;
  localparam int         OPCODE_CLKS       = 8;

  localparam int          CNT_W     = 12;
  localparam logic [11:0] CNT_FIRST = 12'h001;
  localparam logic [11:0] CNT_MAX   = 12'hFFF;
  localparam int          CMD_W     = 40;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_PUSH = 2'b10
  } fcf_state_t;
endpackage

// [design/fcf_frontend.sv]
// Purpose: Serial flash command front end with extended address register.
// Assumes: sclk stops while csN is high; frames are spaced by several clk_sys cycles.
// Notes: Array, status field and data phase engines sit outside this block.
`timescale 1ns/1ps
`default_nettype none
module fcf_frontend #(
  parameter int DTR_DUMMY = fcf_pkg::DTR_DUMMY_CLKS,
  parameter int BUF_W     = fcf_pkg::CMD_W
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             sclk,
  input  wire logic             csN,
  input  wire logic             si,
  input  wire logic             powerUpWideAddress,
  output logic      [3:0]       ioOut,
  output logic      [3:0]       ioOe,
  output logic                  execValid,
  output logic      [BUF_W-1:0] execCmd,
  input  wire logic             execReady,
  output logic                  writeLatch,
  output logic                  wideAddressStatus,
  output logic      [7:0]       extendedAddressControl
);

  function automatic logic isGatedOp(input logic [7:0] op);
    isGatedOp = op inside {fcf_pkg::OP_WRITE_EN, fcf_pkg::OP_WRITE_DIS,
                           fcf_pkg::OP_WRITE_STAT12, fcf_pkg::OP_WRITE_STAT3,
                           fcf_pkg::OP_PROG_WIDE, fcf_pkg::OP_QPROG_WIDE,
                           fcf_pkg::OP_SECT_ERASE, fcf_pkg::OP_CHIP_ERASE_A,
                           fcf_pkg::OP_CHIP_ERASE_B, fcf_pkg::OP_POWER_DOWN};
  endfunction

  function automatic logic isArrayOp(input logic [7:0] op);
    isArrayOp = op inside {fcf_pkg::OP_WRITE_STAT12, fcf_pkg::OP_WRITE_STAT3,
                           fcf_pkg::OP_PROG_WIDE, fcf_pkg::OP_QPROG_WIDE,
                           fcf_pkg::OP_SECT_ERASE, fcf_pkg::OP_CHIP_ERASE_A,
                           fcf_pkg::OP_CHIP_ERASE_B};
  endfunction

  // Whole bytes a frame needs, opcode included
  function automatic logic [8:0] needBytes(input logic [7:0] op, input logic wide);
    logic [8:0] addr;
    addr = wide ? 9'(fcf_pkg::ADDR_BYTES_WIDE) : 9'(fcf_pkg::ADDR_BYTES_NARROW);
    if (op == fcf_pkg::OP_PROG_WIDE || op == fcf_pkg::OP_QPROG_WIDE) begin
      needBytes = addr + 9'h002;
    end else if (op == fcf_pkg::OP_SECT_ERASE) begin
      needBytes = addr + 9'h001;
    end else if (op == fcf_pkg::OP_WRITE_STAT12 || op == fcf_pkg::OP_WRITE_STAT3) begin
      needBytes = 9'h002;
    end else begin
      needBytes = 9'h001;
    end
  endfunction
  // Link domain (sclk)
  logic              armed;
  logic [11:0]       lCnt, patBase, patIdx;
  logic [7:0]        lShift, lOp, lByte1, newByte, regData, eaMeta, eaLink;
  logic [31:0]       lAddr;
  logic              wideMeta, wideLink, wlMeta, wlLink;
  logic [3:0]        loOut, loOe, hiOut, hiOe;
  logic [8:0]        lIdx, lAddrLen;
  logic              regRead, patOn;
  // Set while deselected so the first rising edge restarts the frame
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      armed <= 1'b1;
    end else begin
      armed <= 1'b0;
    end
  end

  // Config crosses as quasi-static levels; it only changes between frames
  always_ff @(posedge sclk) begin
    eaMeta   <= extendedAddressControl;
    eaLink   <= eaMeta;
    wideMeta <= wideAddressStatus;
    wideLink <= wideMeta;
    wlMeta   <= writeLatch;
    wlLink   <= wlMeta;
  end

  assign newByte  = {lShift[6:0], si};
  assign lIdx     = lCnt[11:3];
  assign lAddrLen = wideLink ? 9'(fcf_pkg::ADDR_BYTES_WIDE) : 9'(fcf_pkg::ADDR_BYTES_NARROW);

  // Counter survives the select rise so the sys side can judge alignment
  always_ff @(posedge sclk) begin
    if (armed) begin
      lCnt <= fcf_pkg::CNT_FIRST;
    end else if (lCnt != fcf_pkg::CNT_MAX) begin
      lCnt <= lCnt + 12'h001;
    end
    lShift <= newByte;
  end

  always_ff @(posedge sclk) begin
    if (!armed && lCnt[2:0] == 3'h7) begin
      if (lIdx == 9'h000) begin
        lOp <= newByte;
      end
      if (lIdx == 9'h001) begin
        lByte1 <= newByte;
      end
      if (lIdx != 9'h000 && lIdx <= lAddrLen) begin
        lAddr <= {lAddr[23:0], newByte};
      end
    end
  end

  always_comb begin
    regRead = 1'b0;
    regData = fcf_pkg::STAT1_BASE;
    if (lOp == fcf_pkg::OP_READ_STAT1) begin
      regRead = 1'b1;
      regData[fcf_pkg::STAT1_WL_BIT] = wlLink;
    end else if (lOp == fcf_pkg::OP_READ_EXT) begin
      regRead = 1'b1;
      regData = eaLink;
    end
  end

  // Launched half a clock ahead so the last bit lands in the final dummy
  assign patBase = 12'(fcf_pkg::OPCODE_CLKS + fcf_pkg::DTR_MODE_CLKS
                   + DTR_DUMMY - fcf_pkg::LEARN_CLKS) + 12'(lAddrLen);
  assign patIdx  = lCnt - patBase;
  assign patOn   = lOp == fcf_pkg::OP_DTR_QREAD && eaLink[fcf_pkg::EXT_LPE_BIT]
                   && lCnt >= patBase && patIdx < 12'(fcf_pkg::LEARN_CLKS);

  // Falling edge half: serial read bits and even pattern bits
  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      loOut <= 4'h0;
      loOe  <= 4'h0;
    end else begin
      loOut <= 4'h0;
      loOe  <= 4'h0;
      if (regRead && lCnt >= 12'(fcf_pkg::OPCODE_CLKS)) begin
        loOut[1] <= regData[3'h7 - lCnt[2:0]];
        loOe[1]  <= 1'b1;
      end else if (patOn) begin
        loOut <= {4{fcf_pkg::LEARN_PATTERN[3'(3'h7 - {patIdx[1:0], 1'b0})]}};
        loOe  <= 4'hF;
      end
    end
  end

  // Rising edge half: odd pattern bits, otherwise hold the falling value
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      hiOut <= 4'h0;
      hiOe  <= 4'h0;
    end else if (patOn) begin
      hiOut <= {4{fcf_pkg::LEARN_PATTERN[3'(3'h6 - {patIdx[1:0], 1'b0})]}};
      hiOe  <= 4'hF;
    end else begin
      hiOut <= loOut;
      hiOe  <= loOe;
    end
  end

  // Double data rate needs the clock as select; both halves are flops
  assign ioOut = sclk ? hiOut : loOut;
  assign ioOe  = sclk ? hiOe : loOe;
  // System domain (clk_sys)
  logic                csMeta, csSync, csLast, strapMeta, strapSync;
  logic                csRise, hasOp, okFrame, accepted, pushCmd;
  logic [31:0]         fullAddr;
  fcf_pkg::fcf_state_t state;
  logic [BUF_W-1:0]    pend, spare;
  logic                spareValid, bufInValid, bufInReady;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      csMeta <= 1'b1;
      csSync <= 1'b1;
      csLast <= 1'b1;
    end else begin
      csMeta <= csN;
      csSync <= csMeta;
      csLast <= csSync;
    end
  end

  always_ff @(posedge clk_sys) begin
    strapMeta <= powerUpWideAddress;
    strapSync <= strapMeta;
  end

  // Link summary is stable here: sclk has stopped since the select rise
  assign csRise   = csSync && !csLast;
  assign hasOp    = lCnt >= 12'(fcf_pkg::OPCODE_CLKS);
  assign okFrame  = !isGatedOp(lOp) || lCnt[2:0] == 3'h0;
  assign accepted = isArrayOp(lOp) && okFrame && writeLatch
                    && lIdx >= needBytes(lOp, wideAddressStatus);
  assign pushCmd  = hasOp && (accepted || (lOp == fcf_pkg::OP_POWER_DOWN && okFrame));
  assign fullAddr = wideAddressStatus ? lAddr
                    : {7'h00, extendedAddressControl[fcf_pkg::EXT_URS_BIT], lAddr[23:0]};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      writeLatch <= 1'b0;
    end else if (csRise && hasOp && okFrame) begin
      if (lOp == fcf_pkg::OP_WRITE_EN) begin
        writeLatch <= 1'b1;
      end else if (lOp == fcf_pkg::OP_WRITE_DIS || accepted) begin
        writeLatch <= 1'b0;
      end
    end
  end

  // Reserved bits are held at zero whatever is written
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      extendedAddressControl <= fcf_pkg::EXT_RESET;
    end else if (csRise && lOp == fcf_pkg::OP_WRITE_EXT && lIdx >= 9'h002) begin
      extendedAddressControl <= lByte1 & fcf_pkg::EXT_KEEP_MASK;
    end
  end

  // Strap is sampled by the clocked reset, never asynchronously
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wideAddressStatus <= strapSync;
    end else if (csRise && hasOp && lOp == fcf_pkg::OP_ENTER_WIDE) begin
      wideAddressStatus <= 1'b1;
    end else if (csRise && hasOp && lOp == fcf_pkg::OP_EXIT_WIDE) begin
      wideAddressStatus <= 1'b0;
    end
  end

  // A frame that closes while one still waits here is not queued
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= fcf_pkg::ST_IDLE;
    end else begin
      unique case (state)
        fcf_pkg::ST_IDLE: begin
          if (csRise && pushCmd) begin
            state <= fcf_pkg::ST_PUSH;
          end
        end
        fcf_pkg::ST_PUSH: begin
          if (bufInReady) begin
            state <= fcf_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= fcf_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pend <= '0;
    end else if (state == fcf_pkg::ST_IDLE && csRise && pushCmd) begin
      pend <= BUF_W'({lOp, fullAddr});
    end
  end

  assign bufInValid = state == fcf_pkg::ST_PUSH;
  assign bufInReady = !spareValid;

  // Two-entry skid buffer: output stage plus one spare
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      execValid  <= 1'b0;
      execCmd    <= '0;
      spareValid <= 1'b0;
      spare      <= '0;
    end else if (execValid && execReady) begin
      if (spareValid) begin
        execCmd    <= spare;
        spareValid <= 1'b0;
      end else if (bufInValid) begin
        execCmd <= pend;
      end else begin
        execValid <= 1'b0;
      end
    end else if (bufInValid && bufInReady) begin
      if (!execValid) begin
        execCmd   <= pend;
        execValid <= 1'b1;
      end else begin
        spare      <= pend;
        spareValid <= 1'b1;
      end
    end
  end
  // Checks
  a_wren_sets_latch: assert property (@(posedge clk_sys) disable iff (rst)
    csRise && lOp == fcf_pkg::OP_WRITE_EN && lCnt == 12'h008 |=> writeLatch)
    else $error("Aligned write enable did not set the latch");
  a_misaligned_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    csRise && hasOp && isGatedOp(lOp) && lCnt[2:0] != 3'h0 |=> $stable(writeLatch)
    && state == fcf_pkg::ST_IDLE || $past(state) == fcf_pkg::ST_PUSH)
    else $error("Misaligned write-type command took effect");
  a_partial_keeps_latch: assert property (@(posedge clk_sys) disable iff (rst)
    csRise && writeLatch && lOp == fcf_pkg::OP_PROG_WIDE && lCnt[2:0] != 3'h0
    |=> writeLatch)
    else $error("Partial program byte cleared the latch");
  a_latch_gates_array: assert property (@(posedge clk_sys) disable iff (rst)
    state == fcf_pkg::ST_IDLE && csRise && !writeLatch && isArrayOp(lOp)
    |=> state == fcf_pkg::ST_IDLE)
    else $error("Array command queued without the latch");
  a_ext_write: assert property (@(posedge clk_sys) disable iff (rst)
    csRise && lOp == fcf_pkg::OP_WRITE_EXT && lIdx >= 9'h002
    |=> extendedAddressControl == ($past(lByte1) & fcf_pkg::EXT_KEEP_MASK))
    else $error("Extended register write lost");
  a_region_bit: assert property (@(posedge clk_sys) disable iff (rst)
    state == fcf_pkg::ST_IDLE && csRise && pushCmd && !wideAddressStatus
    |=> pend[24] == extendedAddressControl[fcf_pkg::EXT_URS_BIT])
    else $error("Region bit not used as address bit 24");
  a_enter_wide: assert property (@(posedge clk_sys) disable iff (rst)
    csRise && hasOp && lOp == fcf_pkg::OP_ENTER_WIDE |=> wideAddressStatus ##1 1'b1)
    else $error("Enter wide mode ignored");
  a_exit_wide: assert property (@(posedge clk_sys) disable iff (rst)
    csRise && hasOp && lOp == fcf_pkg::OP_EXIT_WIDE |=> !wideAddressStatus)
    else $error("Exit wide mode ignored");
  // Strap synchroniser is unknown for its first two edges
  a_reset_mode: assert property (@(posedge clk_sys)
    rst && $past(rst) && $past(rst, 2) |=> wideAddressStatus == $past(strapSync))
    else $error("Reset mode does not follow strap");
  a_exec_holds: assert property (@(posedge clk_sys) disable iff (rst)
    execValid && !execReady |=> execValid && $stable(execCmd))
    else $error("Queued command dropped under stall");
  a_pattern_drive: assert property (@(posedge sclk) disable iff (csN)
    patOn |-> loOe == 4'hF
    && loOut == {4{fcf_pkg::LEARN_PATTERN[3'(3'h7 - {patIdx[1:0], 1'b0})]}})
    else $error("Learning pattern bit wrong");
  a_pattern_off: assert property (@(posedge sclk) disable iff (csN)
    lOp == fcf_pkg::OP_DTR_QREAD && !eaLink[fcf_pkg::EXT_LPE_BIT]
    && lCnt > 12'(fcf_pkg::OPCODE_CLKS) |-> loOe == 4'h0)
    else $error("Pattern driven while disabled");

endmodule
`default_nettype wire

// [bench/fcf_ctrl_model.sv]
// Purpose: Serial flash controller model that drives frames into the front end.
// Assumes: Link clock of 80 ns, running only while select is low.
// Notes: Tasks are called from the bench; captured read data sits in variables.
`timescale 1ns/1ps
`default_nettype none
module fcf_ctrl_model (
  output logic            csN,
  output logic            sclk,
  output logic            si,
  input  wire logic [3:0] ioOut,
  input  wire logic [3:0] ioOe
);
  logic [7:0] rd;
  logic [7:0] pat [4];
  logic [3:0] oeOr;
  logic [3:0] oeLast;

  initial begin
    csN = 1'b0;
    sclk = 1'b0;
    si = 1'b0;
    // A real rising select at start arms the frame logic
    #1 csN = 1'b1;
  end

  task automatic grab();
    for (int k = 0; k < 4; k++) begin
      pat[k] = {pat[k][6:0], ioOut[k]};
    end
    oeOr = oeOr | ioOe;
    oeLast = ioOe;
  endtask

  // One frame: nb bits MSB first, then nr output clocks, then deselect
  task automatic xfer(input logic [47:0] d, input int nb, input int nr);
    csN = 1'b0;
    oeOr = 4'h0;
    for (int i = 0; i < nb + nr; i++) begin
      // Past the command the line toggles, so no stale value looks valid
      si = (i < nb) ? d[47-i] : ~si;
      #20;
      if (i >= nb) begin
        grab();
      end
      #20 sclk = 1'b1;
      #20;
      if (i >= nb) begin
        rd = {rd[6:0], ioOut[1]};
        grab();
      end
      #20 sclk = 1'b0;
    end
    #40 csN = 1'b1;
    si = ~si;
    // Long gap lets config settle before the next frame
    #200;
  endtask
endmodule
`default_nettype wire

// [bench/tb_flash_cmd_frontend_ext_addr.sv]
// Purpose: Self-checking bench for the flash command front end.
// Assumes: Commands land well within twelve system clocks of select rising.
// Notes: Ordinary frames run from a table; reads, buffering and reset by hand.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin n_errors++; \
  $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module tb_flash_cmd_frontend_ext_addr;
  // k: 0 no command out, 1 opcode only, 2 whole word; wl 2 = not checked
  typedef struct {bit we; logic [47:0] d; int n; int k; logic [39:0] cmd;
                  int wl; logic wide; logic [7:0] ext;} fcf_row_t;
  localparam int DUMMY = 10;
  logic        clk_sys, rst, powerUpWideAddress, execReady;
  logic        csN, sclk, si, execValid, writeLatch, wideAddressStatus;
  logic [3:0]  ioOut, ioOe;
  logic [39:0] execCmd, lastCmd;
  logic [7:0]  extendedAddressControl;
  int          n_errors, tests_run, takes, cycles, t0;
  fcf_row_t rows [23] = '{
    '{0, 48'h0600_0000_0000, 8, 0, 40'h0, 1, 0, 8'h00},
    '{0, 48'h0400_0000_0000, 9, 0, 40'h0, 1, 0, 8'h00},
    '{0, 48'h0400_0000_0000, 8, 0, 40'h0, 0, 0, 8'h00},
    '{0, 48'h2112_3456_0000, 32, 0, 40'h0, 0, 0, 8'h00},
    '{1, 48'hC501_0000_0000, 16, 0, 40'h0, 1, 0, 8'h01},
    '{1, 48'h2112_3456_0000, 32, 2, 40'h21_0112_3456, 2, 0, 8'h01},
    '{1, 48'h1212_3456_0000, 36, 0, 40'h0, 1, 0, 8'h01},
    '{0, 48'hC500_0000_0000, 16, 0, 40'h0, 1, 0, 8'h00},
    '{1, 48'h2112_3456_0000, 32, 2, 40'h21_0012_3456, 2, 0, 8'h00},
    '{0, 48'hC5FF_0000_0000, 16, 0, 40'h0, 2, 0, 8'h81},
    '{0, 48'hB700_0000_0000, 8, 0, 40'h0, 2, 1, 8'h81},
    '{1, 48'h2100_2345_6700, 40, 2, 40'h21_0023_4567, 2, 1, 8'h81},
    '{1, 48'h2112_3456_0000, 32, 0, 40'h0, 1, 1, 8'h81},
    '{0, 48'hE900_0000_0000, 8, 0, 40'h0, 1, 0, 8'h81},
    '{0, 48'h2112_3456_0000, 32, 2, 40'h21_0112_3456, 2, 0, 8'h81},
    '{1, 48'hC700_0000_0000, 8, 1, 40'hC7_0000_0000, 2, 0, 8'h81},
    '{1, 48'h6000_0000_0000, 8, 1, 40'h60_0000_0000, 2, 0, 8'h81},
    '{1, 48'h0112_3400_0000, 24, 1, 40'h01_0000_0000, 2, 0, 8'h81},
    '{1, 48'h1112_0000_0000, 16, 1, 40'h11_0000_0000, 2, 0, 8'h81},
    '{1, 48'h1212_3456_AB00, 40, 1, 40'h12_0000_0000, 2, 0, 8'h81},
    '{0, 48'hB900_0000_0000, 8, 1, 40'hB9_0000_0000, 2, 0, 8'h81},
    '{0, 48'hB900_0000_0000, 12, 0, 40'h0, 2, 0, 8'h81},
    '{1, 48'h0400_0000_0000, 7, 0, 40'h0, 1, 0, 8'h81}};

  fcf_frontend #(.DTR_DUMMY(DUMMY), .BUF_W(40)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .csN(csN), .si(si),
    .powerUpWideAddress(powerUpWideAddress), .ioOut(ioOut), .ioOe(ioOe),
    .execValid(execValid), .execCmd(execCmd), .execReady(execReady),
    .writeLatch(writeLatch), .wideAddressStatus(wideAddressStatus),
    .extendedAddressControl(extendedAddressControl));
  fcf_ctrl_model u_ctrl (.csN(csN), .sclk(sclk), .si(si), .ioOut(ioOut), .ioOe(ioOe));

  always #4 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (execValid === 1'b1 && execReady === 1'b1) begin
      takes <= takes + 1;
      lastCmd <= execCmd;
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Bounded run: a hang counts against the result
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      $display("BAD timeout exp %0h got %0h", 0, cycles);
      final_report();
    end
  end

  task automatic settle();
    repeat (12) @(posedge clk_sys);
    #1;
  endtask

  task automatic apply_reset(input logic strap);
    @(posedge clk_sys);
    rst <= 1'b1;
    powerUpWideAddress <= strap;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    settle();
    `CHK("wideAfterReset", strap, wideAddressStatus)
    `CHK("extAfterReset", 8'h00, extendedAddressControl)
    `CHK("latchAfterReset", 1'b0, writeLatch)
    $display("reset test strap %0d done", strap);
  endtask

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    powerUpWideAddress = 1'b0;
    execReady = 1'b0;
    {n_errors, tests_run, takes, cycles} = '0;
    @(posedge clk_sys);
    execReady <= 1'b1;
    apply_reset(1'b0);
    foreach (rows[i]) begin
      t0 = takes;
      if (rows[i].we) u_ctrl.xfer(48'h0600_0000_0000, 8, 0);
      u_ctrl.xfer(rows[i].d, rows[i].n, 0);
      settle();
      `CHK("execCount", (rows[i].k != 0) ? 1 : 0, takes - t0)
      if (rows[i].k == 1) `CHK("execOp", rows[i].cmd[39:32], lastCmd[39:32])
      if (rows[i].k == 2) `CHK("execCmd", rows[i].cmd, lastCmd)
      if (rows[i].wl < 2) `CHK("writeLatch", rows[i].wl[0], writeLatch)
      `CHK("wideStatus", rows[i].wide, wideAddressStatus)
      `CHK("extReg", rows[i].ext, extendedAddressControl)
      $display("row %0d done", i);
    end
    // Reads shift out straight after the opcode; latch still set here
    u_ctrl.xfer(48'hC800_0000_0000, 8, 8);
    `CHK("extRead", 8'h81, u_ctrl.rd)
    u_ctrl.xfer(48'h0500_0000_0000, 8, 8);
    `CHK("statusRead", 8'h02, u_ctrl.rd)
    u_ctrl.xfer(48'hC800_0000_0000, 8, 3);
    `CHK("shortRead", 3'b100, u_ctrl.rd[2:0])
    `CHK("oeAfterRead", 4'h0, ioOe)
    $display("read test done");
    u_ctrl.xfer(48'hED00_0000_0000, 12, DUMMY);
    for (int k = 0; k < 4; k++) `CHK("learnLane", 8'b0011_0100, u_ctrl.pat[k])
    `CHK("learnOe", 4'hF, u_ctrl.oeLast)
    u_ctrl.xfer(48'hC500_0000_0000, 16, 0);
    u_ctrl.xfer(48'h0500_0000_0000, 8, 8);
    u_ctrl.xfer(48'hED00_0000_0000, 12, DUMMY);
    `CHK("noLearnOe", 4'h0, u_ctrl.oeOr)
    $display("learning pattern test done");
    // Engine stalls: two buffered, one pending, the fourth is dropped
    @(posedge clk_sys);
    execReady <= 1'b0;
    t0 = takes;
    repeat (4) u_ctrl.xfer(48'hB900_0000_0000, 8, 0);
    settle();
    `CHK("stallValid", 1'b1, execValid)
    `CHK("stallTakes", 0, takes - t0)
    execReady <= 1'b1;
    settle();
    `CHK("drainTakes", 3, takes - t0)
    `CHK("drainValid", 1'b0, execValid)
    $display("buffer test done");
    apply_reset(1'b1);
    apply_reset(1'b0);
    final_report();
  end
endmodule
`default_nettype wire
